//--- rtl/two_wire_register_slave.sv
// two-wire serial slave giving an external master access to the
// device's 16-bit registers through an 8-bit pointer
// assumes: scl/sda are pins sampled by clk_in (25 MHz), the master
// clock is far slower; the register file sits outside on reg_*
//
// Function
// - address 0x90 when select pin xor invert bit low, else 0xba
// - start, then 8-bit address; lsb zero writes, one reads
// - acknowledge our own slave address
// - in a write the first byte is the pointer, acknowledged
// - write data moves in bytes, each one acknowledged
// - one register write takes two consecutive data bytes
// - pointer increments after every 16 written bits, except at the staging address
// - read shifts out one byte per eight clocks, master acks
// - pointer advances after every 16 bits sent, except at the staging address
// - master no-acknowledge ends a read, device releases data
// - idle is both lines high; only master makes start or stop
// - start is data falling while clock high
// - stop is data rising while clock high
// - data changes only while clock low, stable while high
// - ninth clock: transmitter releases, receiver pulls low
// - data left high in the ack clock is a no-acknowledge
// - data line driven only low, pull-up gives high
// - select pin high, invert clear: write 0xba, read 0xbb
// - a register changes only when both bytes are in
// - byte write: held upper byte completes via staging address
// - byte read: lower byte comes from the staging address
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_defs.svh"

module two_wire_register_slave #(
  parameter int PTR_W = 8,
  parameter int REG_W = 16
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // serial bus pins
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output var  logic             sda_out,
  output var  logic             sda_oe_out,
  // address selection
  input  wire logic             address_select_pin_in,
  input  wire logic             address_invert_bit_in,
  // register file port
  output var  logic             reg_wr_out,
  output var  logic [PTR_W-1:0] reg_wr_addr_out,
  output var  logic [REG_W-1:0] reg_wdata_out,
  output var  logic [PTR_W-1:0] reg_rd_addr_out,
  input  wire logic [REG_W-1:0] reg_rdata_in
);

  ////////////////////////////////////////////////////////////////
  // line sampling

  bus_events_if ev ();

  line_sampler u_sampler (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .ev     (ev)
  );

  // the select pin is a strap from outside the clock domain
  logic sel_s1_ff;
  logic sel_s2_ff;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sel_s1_ff <= 1'b0;
      sel_s2_ff <= 1'b0;
    end
    else
    begin
      sel_s1_ff <= address_select_pin_in;
      sel_s2_ff <= sel_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // state

  tw_pkg::st_t        state_ff;
  tw_pkg::st_t        nxt_state;
  logic [2:0]         bit_cnt_ff;
  logic [7:0]         shift_ff;
  logic               rw_ff;       // transaction reads
  logic               ptr_done_ff; // pointer byte already in
  logic               hi_next_ff;  // next data byte is the upper one
  logic               drive_low_ff;
  logic               mack_ff;     // master acknowledged last byte
  logic [PTR_W-1:0]   ptr_ff;
  logic [7:0]         upper_ff;    // held upper byte
  logic [PTR_W-1:0]   stage_addr_ff;
  logic [7:0]         stage_lo_ff; // lower byte for reads
  logic               wr_ff;
  logic [PTR_W-1:0]   wr_addr_ff;
  logic [REG_W-1:0]   wdata_ff;

  ////////////////////////////////////////////////////////////////
  // decode

  wire       in_addr   = state_ff == tw_pkg::st_addr;
  wire       in_recv   = state_ff == tw_pkg::st_recv;
  wire       in_ackout = state_ff == tw_pkg::st_ackout;
  wire       in_send   = state_ff == tw_pkg::st_send;
  wire       in_ackin  = state_ff == tw_pkg::st_ackin;
  wire       frame     = ev.start | ev.stop;
  wire [7:0] rx_byte   = {shift_ff[6:0], ev.sda};
  wire       rx_done   = ev.rise && (bit_cnt_ff == `LAST_BIT);
  // address picked by pin xor invert bit
  wire [7:0] own_addr  = (sel_s2_ff ^ address_invert_bit_in)
                         ? `SLAVE_ADDR_HI : `SLAVE_ADDR_LO;
  // compare seven bits, lsb is direction
  wire       addr_hit  = rx_byte[7:1] == own_addr[7:1];
  wire       at_stage  = ptr_ff == `STAGE_PTR;
  wire       byte_in   = in_recv && rx_done;
  // first byte of a write is the pointer
  wire       ptr_take  = byte_in && !ptr_done_ff;
  wire       hi_take   = byte_in && ptr_done_ff && hi_next_ff
                         && !at_stage;
  wire       stage_wr  = byte_in && ptr_done_ff && at_stage;
  wire       word_wr   = byte_in && ptr_done_ff && !hi_next_ff
                         && !at_stage;
  wire       ack_rel   = in_ackout && ev.fall && drive_low_ff;
  wire       load_tx   = (ack_rel && rw_ff)
                         || (in_ackin && ev.fall && mack_ff);
  wire       load_hi   = load_tx && hi_next_ff && !at_stage;
  // staging address and lower half both give stage_lo_ff
  wire [7:0] tx_byte   = load_hi ? reg_rdata_in[REG_W-1:REG_W-8]
                                 : stage_lo_ff;
  // lower byte of a register fully sent
  wire       rd_step   = in_send && rx_done && hi_next_ff && !at_stage;

  ////////////////////////////////////////////////////////////////
  // next state; start and stop override everything

  always_comb
  begin
    nxt_state = state_ff;
    // start or stop aborts any byte
    if (ev.start)
      nxt_state = tw_pkg::st_addr;
    else if (ev.stop)
      nxt_state = tw_pkg::st_idle;
    else
    begin
      unique case (state_ff)
        tw_pkg::st_idle:   nxt_state = tw_pkg::st_idle;
        // foreign address: back to idle, no ack
        tw_pkg::st_addr:
          if (rx_done)
            nxt_state = addr_hit ? tw_pkg::st_ackout
                                 : tw_pkg::st_idle;
        tw_pkg::st_recv:
          if (rx_done)
            nxt_state = tw_pkg::st_ackout;
        tw_pkg::st_ackout:
          if (ack_rel)
            nxt_state = rw_ff ? tw_pkg::st_send : tw_pkg::st_recv;
        tw_pkg::st_send:
          if (rx_done)
            nxt_state = tw_pkg::st_ackin;
        // data high in ack clock ends read
        tw_pkg::st_ackin:
          if (ev.rise && ev.sda)
            nxt_state = tw_pkg::st_idle;
          else if (load_tx)
            nxt_state = tw_pkg::st_send;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register and bit counter

  // counter wraps 7 -> 0 on its own between bytes; start and stop clear it
  always_ff @(posedge clk_in)
  begin
    if (rst_in || frame)
      bit_cnt_ff <= 3'h0;
    else if (ev.rise && (in_addr || in_recv || in_send))
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_ff <= tw_pkg::st_idle;
    else
      state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////
  // shift register

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      shift_ff <= `BYTE_RST;
    else if (ev.rise && (in_addr || in_recv))
      shift_ff <= rx_byte;
    else if (load_tx)
      shift_ff <= tx_byte;
    else if (in_send && ev.fall)
      shift_ff <= {shift_ff[6:0], 1'b0};
  end

  ////////////////////////////////////////////////////////////////
  // transaction flags

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rw_ff <= 1'b0;
    else if (in_addr && rx_done)
      rw_ff <= rx_byte[0];
  end

  // a new start expects a fresh pointer and an upper byte first
  always_ff @(posedge clk_in)
  begin
    if (rst_in || ev.start)
    begin
      ptr_done_ff <= 1'b0;
      hi_next_ff  <= 1'b1;
    end
    else
    begin
      if (ptr_take)
        ptr_done_ff <= 1'b1;
      if (hi_take || load_hi)
        hi_next_ff <= 1'b0;
      else if (word_wr || (load_tx && !hi_next_ff))
        hi_next_ff <= 1'b1;
    end
  end

  // master acknowledge, sampled on the ninth clock rise
  always_ff @(posedge clk_in)
  begin
    if (rst_in || frame || load_tx)
      mack_ff <= 1'b0;
    else if (in_ackin && ev.rise)
      mack_ff <= !ev.sda;
  end

  ////////////////////////////////////////////////////////////////
  // data line drive

  // only ever pull low; the pull-up makes the high level
  logic nxt_drive;

  always_comb
  begin
    nxt_drive = drive_low_ff;
    if (frame)
      nxt_drive = 1'b0;
    // new bit only on a clock fall; the fall that
    // ends the address ack must put out bit 7, not merely release
    else if (load_tx)
      nxt_drive = !tx_byte[7];
    // pull low for the ack clock, release after it
    else if (in_ackout && ev.fall)
      nxt_drive = !drive_low_ff;
    else if (in_send && ev.fall)
      nxt_drive = !shift_ff[6];
    // release for the master's ack clock
    else if (in_ackin && ev.fall)
      nxt_drive = 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      drive_low_ff <= 1'b0;
    else
      drive_low_ff <= nxt_drive;
  end

  ////////////////////////////////////////////////////////////////
  // pointer and staging

  // step after the lower byte of a write lands or the lower byte of a read is sent
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ptr_ff <= `PTR_RST;
    else if (ptr_take)
      ptr_ff <= rx_byte;
    else if (word_wr || rd_step)
      ptr_ff <= ptr_ff + 8'h01;
  end

  // upper byte and its register held for a later stage write
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      upper_ff      <= `BYTE_RST;
      stage_addr_ff <= `PTR_RST;
    end
    else if (hi_take)
    begin
      upper_ff      <= rx_byte;
      stage_addr_ff <= ptr_ff;
    end
  end

  // lower half kept when the upper half is read
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      stage_lo_ff <= `BYTE_RST;
    else if (load_hi)
      stage_lo_ff <= reg_rdata_in[7:0];
  end

  ////////////////////////////////////////////////////////////////
  // register write strobe

  // a register is written only with both bytes present
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ff      <= 1'b0;
      wr_addr_ff <= `PTR_RST;
      wdata_ff   <= `WORD_RST;
    end
    else
    begin
      wr_ff <= word_wr || stage_wr;
      if (word_wr || stage_wr)
      begin
        wr_addr_ff <= stage_wr ? stage_addr_ff : ptr_ff;
        wdata_ff   <= {upper_ff, rx_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs, all from flops

  logic sda_lvl_ff; // level driven while enabled: always low

  always_ff @(posedge clk_in)
  begin
    sda_lvl_ff <= 1'b0;
  end

  assign sda_out         = sda_lvl_ff;
  assign sda_oe_out      = drive_low_ff;
  assign reg_wr_out      = wr_ff;
  assign reg_wr_addr_out = wr_addr_ff;
  assign reg_wdata_out   = wdata_ff;
  assign reg_rd_addr_out = ptr_ff;

  ////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_addr_match;
    in_addr && rx_done && addr_hit && !frame;
  endsequence

  sequence s_addr_miss;
    in_addr && rx_done && !addr_hit && !frame;
  endsequence

  sequence s_ack_begin;
    in_ackout && ev.fall && !drive_low_ff && !frame;
  endsequence

  chk_addr_select: assert property (
    s_addr_match |=> state_ff == tw_pkg::st_ackout
                     && rw_ff == $past(rx_byte[0]))
    else $error("own address not taken");

  chk_addr_reject: assert property (
    s_addr_miss |=> state_ff == tw_pkg::st_idle && !drive_low_ff)
    else $error("foreign address not ignored");

  chk_ack_drive: assert property (
    s_ack_begin |=> drive_low_ff ##1 (drive_low_ff || frame))
    else $error("ack not driven low after byte");

  chk_ptr_load: assert property (
    ptr_take && !frame |=> ptr_ff == $past(rx_byte))
    else $error("pointer byte not loaded");

  chk_pair_commit: assert property (
    reg_wr_out |-> $past(in_recv && ptr_done_ff
                        && (!hi_next_ff || at_stage)))
    else $error("register written without a full word");

  chk_ptr_step: assert property (
    word_wr && !frame |=> ptr_ff == $past(ptr_ff) + 8'h01
                          ##1 reg_wr_out == 1'b0)
    else $error("pointer not stepped after 16 bits");

  chk_nack_release: assert property (
    in_ackin && ev.rise && ev.sda && !frame
      |=> state_ff == tw_pkg::st_idle && !drive_low_ff)
    else $error("no-acknowledge did not end the read");

  chk_change_low: assert property (
    $changed(drive_low_ff) |-> !ev.scl || $past(frame))
    else $error("data line changed while clock high");

  chk_abort_start: assert property (
    ev.start |=> state_ff == tw_pkg::st_addr && bit_cnt_ff == 3'h0
                 && !drive_low_ff)
    else $error("start did not restart address phase");

endmodule

`default_nettype wire

//--- rtl/two_wire_defs.svh
// constants of the two-wire register slave
// assumes: included by bare name from every file that needs it
`ifndef TWO_WIRE_DEFS_SVH
`define TWO_WIRE_DEFS_SVH

// slave addresses, direction bit included (write form)
`define SLAVE_ADDR_LO 8'h90
`define SLAVE_ADDR_HI 8'hba
// pointer value that reaches the byte staging address
`define STAGE_PTR     8'hf1
// bit index of the last bit of a byte
`define LAST_BIT      3'h7
// reset values
`define PTR_RST       8'h00
`define BYTE_RST      8'h00
`define WORD_RST      16'h0000

`endif

//--- rtl/tw_pkg.sv
// types shared by the two-wire register slave
// assumes: nothing; referenced as tw_pkg::name
package tw_pkg;

  // slave state machine, one-hot
  typedef enum logic [5:0] {
    st_idle   = 6'h01,
    st_addr   = 6'h02,
    st_recv   = 6'h04,
    st_ackout = 6'h08,
    st_send   = 6'h10,
    st_ackin  = 6'h20
  } st_t;

endpackage

//--- rtl/bus_events_if.sv
// sampled bus levels and edge events between the line sampler
// and the slave state machine
// assumes: one clock domain, the system clock
`timescale 1ns/1ps
`default_nettype none

interface bus_events_if;
  logic scl;    // synchronised clock line level
  logic sda;    // synchronised data line level
  logic rise;   // clock line rose
  logic fall;   // clock line fell
  logic start;  // start condition seen
  logic stop;   // stop condition seen

  modport src (output scl, sda, rise, fall, start, stop);
  modport snk (input  scl, sda, rise, fall, start, stop);
endinterface

`default_nettype wire

//--- rtl/line_sampler.sv
// synchronises the two bus lines and finds their edges,
// start and stop conditions
// assumes: lines are asynchronous pins, clk_in much faster than scl
`timescale 1ns/1ps
`default_nettype none

module line_sampler (
  // clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  // bus pins
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  // events out
  bus_events_if.src   ev
);

  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic       scl_d_ff;
  logic       sda_d_ff;

  // two flops per line; both lines see the same delay so that
  // data changing just after a clock fall stays ordered
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
    end
  end

  // edge decode on the second stage only
  assign ev.scl   = scl_sync_ff[1];
  assign ev.sda   = sda_sync_ff[1];
  assign ev.rise  = scl_sync_ff[1] & ~scl_d_ff;
  assign ev.fall  = ~scl_sync_ff[1] & scl_d_ff;
  assign ev.start = scl_sync_ff[1] & scl_d_ff & sda_d_ff
                    & ~sda_sync_ff[1];
  assign ev.stop  = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff
                    & sda_sync_ff[1];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_start_detect: assert property (
    ev.start |-> $past(sda_sync_ff[1]) && !sda_sync_ff[1]
                 && $past(scl_sync_ff[1]) && scl_sync_ff[1])
    else $error("start flagged without data fall at clock high");

  chk_stop_detect: assert property (
    ev.stop |-> !$past(sda_sync_ff[1]) && sda_sync_ff[1]
                && $past(scl_sync_ff[1]) && scl_sync_ff[1])
    else $error("stop flagged without data rise at clock high");

endmodule

`default_nettype wire

//--- sim/tw_master_model.sv
// bus master model facing the two-wire register slave
// assumes: clk_in is the 25 MHz bench clock; scl period is 8 clocks,
// 4 low and 4 high, and stands high between frames
`timescale 1ns/1ps
`default_nettype none

module tw_master_model (
  // timing reference
  input  wire logic clk_in,
  // bus lines
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_pull_out
);
  ////////////////////////////////////////////////////////////////////
  // idle bus: both lines released high
  // idle both high
  initial
  begin
    scl_out      = 1'b1;
    sda_pull_out = 1'b0;
  end

  // every move lands 1 ns after a clock edge, never on it
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////
  // start and repeated start; sda released first so it can fall
  // master makes start
  task automatic bus_start();
    w(2);
    sda_pull_out = 1'b0;
    w(4);
    scl_out = 1'b1;
    w(4);
    sda_pull_out = 1'b1;
    w(4);
    scl_out = 1'b0;
  endtask

  task automatic bus_stop();
    w(2);
    sda_pull_out = 1'b1;
    w(4);
    scl_out = 1'b1;
    w(4);
    sda_pull_out = 1'b0;
    w(6);
  endtask

  ////////////////////////////////////////////////////////////////////
  // one pulse; the pull only moves while scl is low
  // pull low only
  task automatic clk_bit(input logic pull, output logic seen);
    w(2);
    sda_pull_out = pull;
    w(2);
    scl_out = 1'b1;
    w(3);
    seen = sda_in;
    w(1);
    scl_out = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(!b[i], s);
    clk_bit(1'b0, s);
    ack = !s;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(1'b0, s);
      b[i] = s;
    end
    clk_bit(!last, s);
  endtask
endmodule

`default_nettype wire

//--- sim/two_wire_register_slave_tb.sv
// self-checking bench for the two-wire register slave
// assumes: tw_master_model drives the bus; an array stands in for
// the register file behind the reg_* port
`timescale 1ns/1ps
`default_nettype none

module two_wire_register_slave_tb;
  logic        clk_in;
  logic        rst_in;
  logic        pin;
  logic        inv;
  logic        scl;
  logic        pull;
  wire  logic  sda;
  logic        sda_oe;
  logic        sda_lvl;
  logic        wr;
  logic [7:0]  wr_addr;
  logic [15:0] wdata;
  logic [7:0]  rd_addr;
  wire  logic [15:0] rdata;
  logic [15:0] regs [256];
  logic [7:0]  wq [$];
  logic [7:0]  rb [4];
  logic        ack;
  logic [7:0]  dev;
  logic [7:0]  a;
  logic [7:0]  p;
  int          cnt;
  int          n_wr;
  int          fail_count;
  int          n_tests;
  int          seed;

  ////////////////////////////////////////////////////////////////////
  // wired and, pull-up
  assign sda   = (sda_oe || pull) ? 1'b0 : 1'b1;
  assign rdata = regs[rd_addr];

  two_wire_register_slave two_wire_register_slave_i (
    .clk_in                (clk_in),
    .rst_in                (rst_in),
    .scl_in                (scl),
    .sda_in                (sda),
    .sda_out               (sda_lvl),
    .sda_oe_out            (sda_oe),
    .address_select_pin_in (pin),
    .address_invert_bit_in (inv),
    .reg_wr_out            (wr),
    .reg_wr_addr_out       (wr_addr),
    .reg_wdata_out         (wdata),
    .reg_rd_addr_out       (rd_addr),
    .reg_rdata_in          (rdata)
  );

  tw_master_model tw_master_model_i (
    .clk_in       (clk_in),
    .sda_in       (sda),
    .scl_out      (scl),
    .sda_pull_out (pull)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // register file; strobes counted to catch stray commits
  always @(posedge clk_in)
  begin
    if (wr === 1'b1)
    begin
      regs[wr_addr] <= wdata;
      n_wr <= n_wr + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ack_is(input logic e);
    check({15'h0000, ack}, {15'h0000, e});
  endtask

  function automatic logic [7:0] exp_addr(input logic s, input logic i);
    return (s ^ i) ? 8'hba : 8'h90;
  endfunction

  // write: address, pointer, queued bytes
  task automatic write_tx(input logic [7:0] ptr);
    tw_master_model_i.bus_start();
    tw_master_model_i.put_byte(dev, ack);
    ack_is(1'b1);
    tw_master_model_i.put_byte(ptr, ack);
    ack_is(1'b1);
    foreach (wq[i])
    begin
      tw_master_model_i.put_byte(wq[i], ack);
      ack_is(1'b1);
    end
    tw_master_model_i.bus_stop();
  endtask

  // read: pointer, repeated start, n bytes, nack on the last
  task automatic read_tx(input logic [7:0] ptr, input int n);
    tw_master_model_i.bus_start();
    tw_master_model_i.put_byte(dev, ack);
    tw_master_model_i.put_byte(ptr, ack);
    ack_is(1'b1);
    tw_master_model_i.bus_start();
    tw_master_model_i.put_byte(dev | 8'h01, ack);
    ack_is(1'b1);
    for (int i = 0; i < n; i++)
      tw_master_model_i.get_byte(i == n - 1, rb[i]);
    check({14'h0000, sda_lvl, sda_oe}, 16'h0000);
    tw_master_model_i.bus_stop();
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // the run needs some 6700 clocks; 20000 means a hang
  initial
  begin
    #800000;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    seed = 32'hf3f3;
    rst_in = 1'b1;
    pin = 1'b0;
    inv = 1'b0;
    fail_count = 0;
    n_tests = 0;
    n_wr = 0;
    for (int i = 0; i < 256; i++)
      regs[i] = 16'($random(seed));
    repeat (10) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    tw_master_model_i.w(4);
    check({7'h00, sda_oe, rd_addr}, 16'h0000);
    // every select combination, both addresses and a foreign one
    for (int k = 0; k < 4; k++)
    begin
      {pin, inv} = k[1:0];
      tw_master_model_i.w(4);
      for (int j = 0; j < 3; j++)
      begin
        a = (j == 0) ? 8'h90 : (j == 1) ? 8'hba :
            (8'h20 | (8'($random(seed)) & 8'h0e));
        tw_master_model_i.bus_start();
        tw_master_model_i.put_byte(a, ack);
        ack_is(a == exp_addr(pin, inv));
        tw_master_model_i.put_byte(8'h00, ack);
        ack_is(a == exp_addr(pin, inv));
        tw_master_model_i.bus_stop();
      end
    end
    pin = 1'b1;
    inv = 1'b0;
    dev = exp_addr(pin, inv);
    tw_master_model_i.w(4);
    // random two-register writes read back in one burst
    for (int r = 0; r < 3; r++)
    begin
      p = 8'($random(seed)) & 8'h7f;
      wq = {};
      repeat (4) wq.push_back(8'($random(seed)));
      cnt = n_wr;
      write_tx(p);
      check(16'(n_wr - cnt), 16'h0002);
      check(regs[p], {wq[0], wq[1]});
      check(regs[p + 8'h01], {wq[2], wq[3]});
      check({8'h00, rd_addr}, {8'h00, p + 8'h02});
      read_tx(p, 4);
      check({rb[0], rb[1]}, regs[p]);
      check({rb[2], rb[3]}, regs[p + 8'h01]);
      check({8'h00, rd_addr}, {8'h00, p + 8'h02});
    end
    // lone upper byte, then lower through the staging address
    p = 8'h09;
    wq = {8'h02};
    cnt = n_wr;
    write_tx(p);
    check(16'(n_wr - cnt), 16'h0000);
    wq = {8'h84};
    write_tx(8'hf1);
    check(regs[p], 16'h0284);
    check(16'(n_wr - cnt), 16'h0001);
    // byte reads: upper from the register, lower from staging
    read_tx(p, 1);
    check({8'h00, rb[0]}, {8'h00, regs[p][15:8]});
    read_tx(8'hf1, 1);
    check({8'h00, rb[0]}, {8'h00, regs[p][7:0]});
    // start four bits into the lower byte must commit no register
    cnt = n_wr;
    tw_master_model_i.bus_start();
    tw_master_model_i.put_byte(dev, ack);
    tw_master_model_i.put_byte(8'h10, ack);
    tw_master_model_i.put_byte(8'h55, ack);
    repeat (4) tw_master_model_i.clk_bit(1'b1, ack);
    tw_master_model_i.bus_start();
    tw_master_model_i.put_byte(dev, ack);
    ack_is(1'b1);
    tw_master_model_i.bus_stop();
    check(16'(n_wr - cnt), 16'h0000);
    wrap_up();
  end
endmodule

`default_nettype wire
